// [hdl/xexec_pkg.sv]
// Constants, register map and opcode encodings for the skip, table-read and XOR execution unit.
`default_nettype none
package xexec_pkg;
	// Data and bus widths.
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PADDR_W = 12;
	localparam int unsigned PM_ADDR_W = 16;
	localparam int unsigned PM_DATA_W = 16;
	localparam int unsigned MEM_DEPTH = 16;
	localparam int unsigned MEM_IDX_W = 4;
	localparam int unsigned OP_W = 4;
	localparam int unsigned BIT_W = 3;

	// Register byte offsets on the APB slave.
	localparam logic [PADDR_W-1:0] OFS_CMD = 12'h000;
	localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h004;
	localparam logic [PADDR_W-1:0] OFS_ACC = 12'h008;
	localparam logic [PADDR_W-1:0] OFS_PTR_LOW = 12'h00c;
	localparam logic [PADDR_W-1:0] OFS_PTR_HIGH = 12'h010;
	localparam logic [PADDR_W-1:0] OFS_HIGH_LATCH = 12'h014;
	localparam logic [PADDR_W-1:0] OFS_FLAGS = 12'h018;
	localparam logic [PADDR_W-1:0] OFS_MEM_BASE = 12'h040;
	localparam logic [PADDR_W-1:0] OFS_MEM_LAST = 12'h07c;

	// Command word fields.
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_BIT_LSB = 4;
	localparam int unsigned CMD_ADR_LSB = 8;

	// Status word fields.
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_SKIP_BIT = 1;
	localparam int unsigned ST_ERR_BIT = 2;
	localparam int unsigned ST_CYC_LSB = 8;

	// Zero flag position inside the flags register.
	localparam int unsigned FLAG_Z_BIT = 2;

	// Opcodes written to the command register.
	localparam logic [OP_W-1:0] OP_SKIP_IF_ZERO = 4'h1;
	localparam logic [OP_W-1:0] OP_SKIP_IF_ZERO_MOVE_ACC = 4'h2;
	localparam logic [OP_W-1:0] OP_SKIP_IF_BIT_ZERO = 4'h3;
	localparam logic [OP_W-1:0] OP_TABLE_READ_PAGE = 4'h4;
	localparam logic [OP_W-1:0] OP_TABLE_READ_LAST_PAGE = 4'h5;
	localparam logic [OP_W-1:0] OP_INC_TABLE_READ_PAGE = 4'h6;
	localparam logic [OP_W-1:0] OP_INC_TABLE_READ_LAST_PAGE = 4'h7;
	localparam logic [OP_W-1:0] OP_XOR_TO_ACC = 4'h8;
	localparam logic [OP_W-1:0] OP_XOR_TO_MEM = 4'h9;

	// Page and cycle constants.
	localparam logic [DATA_W-1:0] LAST_PAGE = 8'hff;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_SKIP = 2'h3;
	localparam logic [1:0] CYC_TABLE = 2'h3;

	// Reset values.
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [PM_ADDR_W-1:0] RST_PM_ADDR = 16'h0000;
endpackage
`default_nettype wire

// [hdl/skip_table_read_xor_exec.sv]
// Execution unit for skip-if-zero, table-read and XOR instructions with an APB register port.
`timescale 1ns/1ps
`default_nettype none
module skip_table_read_xor_exec (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [xexec_pkg::PADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [xexec_pkg::PM_ADDR_W-1:0] pm_addr_o,
	output logic pm_rd_o,
	input wire logic [xexec_pkg::PM_DATA_W-1:0] pm_data_i,
	output logic busy_o,
	output logic done_o,
	output logic skip_o
);

	////////////////////////////////////////////////////////////////////////////////
	// State types.

	typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_TABLE, PH_DUMMY} phase_e;

	typedef struct packed {
		phase_e phase;
		logic [xexec_pkg::DATA_W-1:0] acc;
		logic [xexec_pkg::DATA_W-1:0] flags;
		logic [xexec_pkg::DATA_W-1:0] ptr_low;
		logic [xexec_pkg::DATA_W-1:0] ptr_high;
		logic [xexec_pkg::DATA_W-1:0] high_latch;
		logic [xexec_pkg::MEM_DEPTH-1:0][xexec_pkg::DATA_W-1:0] mem;
		logic [xexec_pkg::OP_W-1:0] op;
		logic [xexec_pkg::BIT_W-1:0] bit_sel;
		logic [xexec_pkg::MEM_IDX_W-1:0] adr;
		logic [1:0] cyc;
		logic last_skip;
		logic last_err;
		logic [1:0] last_cyc;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [xexec_pkg::PM_ADDR_W-1:0] pm_addr;
		logic pm_rd;
		logic done;
		logic skip;
		logic busy;
	} state_s;

	state_s q;
	state_s d;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Data memory window: aligned words from the base to the last slot.
	function automatic logic mem_hit(input logic [xexec_pkg::PADDR_W-1:0] a);
		mem_hit = (a >= xexec_pkg::OFS_MEM_BASE) && (a <= xexec_pkg::OFS_MEM_LAST) && (a[1:0] == 2'h0);
	endfunction

	// Word index of a data memory byte from its bus address.
	function automatic logic [xexec_pkg::MEM_IDX_W-1:0] mem_idx(input logic [xexec_pkg::PADDR_W-1:0] a);
		logic [xexec_pkg::PADDR_W-1:0] rel;
		rel = a - xexec_pkg::OFS_MEM_BASE;
		mem_idx = rel[xexec_pkg::MEM_IDX_W+1:2];
	endfunction

	// Zero test shared by the two skip-if-zero decisions and the XOR flag update.
	function automatic logic is_zero(input logic [xexec_pkg::DATA_W-1:0] v);
		is_zero = (v == xexec_pkg::RST_BYTE);
	endfunction

	// Zero-extends a byte onto the read data bus.
	function automatic logic [31:0] widen(input logic [xexec_pkg::DATA_W-1:0] v);
		widen = {24'h00_0000, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic access;
	logic commit;
	logic busy;
	logic [xexec_pkg::DATA_W-1:0] operand;
	logic [xexec_pkg::DATA_W-1:0] xor_res;
	logic [xexec_pkg::DATA_W-1:0] low_next;

	// Bus slave, instruction sequencing and datapath in one process so that the whole state
	// moves together; bus writes are refused while an instruction runs, which keeps the
	// datapath the only writer of shared state during execution.
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.pm_rd = 1'b0;
		d.done = 1'b0;
		d.skip = 1'b0;
		busy = (q.phase != PH_IDLE);
		access = psel_i && penable_i && !q.pready;
		commit = psel_i && penable_i && q.pready && pwrite_i && !q.pslverr;
		operand = q.mem[q.adr];
		xor_res = q.acc ^ operand;
		low_next = q.ptr_low + 8'h01;

		// Access phase, first cycle: prepare the answer and decide refusal.
		if (access) begin
			d.pready = 1'b1;
			d.prdata = xexec_pkg::RST_WORD;
			if (mem_hit(paddr_i)) begin
				d.prdata = widen(q.mem[mem_idx(paddr_i)]);
				d.pslverr = pwrite_i && busy;
			end else begin
				case (paddr_i)
					xexec_pkg::OFS_CMD: begin
						d.prdata = {16'h0000, 4'h0, q.adr, 1'b0, q.bit_sel, q.op};
						d.pslverr = pwrite_i && busy;
					end
					xexec_pkg::OFS_STATUS: begin
						d.prdata[xexec_pkg::ST_BUSY_BIT] = busy;
						d.prdata[xexec_pkg::ST_SKIP_BIT] = q.last_skip;
						d.prdata[xexec_pkg::ST_ERR_BIT] = q.last_err;
						d.prdata[xexec_pkg::ST_CYC_LSB +: 2] = q.last_cyc;
						d.pslverr = pwrite_i;
					end
					xexec_pkg::OFS_ACC: begin
						d.prdata = widen(q.acc);
						d.pslverr = pwrite_i && busy;
					end
					xexec_pkg::OFS_PTR_LOW: begin
						d.prdata = widen(q.ptr_low);
						d.pslverr = pwrite_i && busy;
					end
					xexec_pkg::OFS_PTR_HIGH: begin
						d.prdata = widen(q.ptr_high);
						d.pslverr = pwrite_i && busy;
					end
					xexec_pkg::OFS_HIGH_LATCH: begin
						d.prdata = widen(q.high_latch);
						d.pslverr = pwrite_i;
					end
					xexec_pkg::OFS_FLAGS: begin
						d.prdata = widen(q.flags);
						d.pslverr = pwrite_i && busy;
					end
					default: begin
						d.pslverr = 1'b1;
					end
				endcase
			end
		end

		// Completion edge of an accepted write: the value takes effect here only.
		if (commit) begin
			if (mem_hit(paddr_i)) begin
				d.mem[mem_idx(paddr_i)] = pwdata_i[xexec_pkg::DATA_W-1:0];
			end else begin
				case (paddr_i)
					xexec_pkg::OFS_CMD: begin
						d.op = pwdata_i[xexec_pkg::CMD_OP_LSB +: xexec_pkg::OP_W];
						d.bit_sel = pwdata_i[xexec_pkg::CMD_BIT_LSB +: xexec_pkg::BIT_W];
						d.adr = pwdata_i[xexec_pkg::CMD_ADR_LSB +: xexec_pkg::MEM_IDX_W];
						d.phase = PH_EXEC;
					end
					xexec_pkg::OFS_ACC: d.acc = pwdata_i[xexec_pkg::DATA_W-1:0];
					xexec_pkg::OFS_PTR_LOW: d.ptr_low = pwdata_i[xexec_pkg::DATA_W-1:0];
					xexec_pkg::OFS_PTR_HIGH: d.ptr_high = pwdata_i[xexec_pkg::DATA_W-1:0];
					xexec_pkg::OFS_FLAGS: d.flags = pwdata_i[xexec_pkg::DATA_W-1:0];
					default: begin
						d.flags = q.flags;
					end
				endcase
			end
		end

		// Instruction sequencing; flags are touched only by the XOR forms.
		case (q.phase)
			PH_IDLE: begin
				d.cyc = 2'h0;
			end
			PH_EXEC: begin
				d.cyc = xexec_pkg::CYC_ONE;
				d.last_err = 1'b0;
				d.last_skip = 1'b0;
				d.last_cyc = xexec_pkg::CYC_ONE;
				d.done = 1'b1;
				d.phase = PH_IDLE;
				case (q.op)
					xexec_pkg::OP_SKIP_IF_ZERO: begin
						d.mem[q.adr] = operand;
						if (is_zero(operand)) begin
							d.phase = PH_DUMMY;
							d.done = 1'b0;
						end
					end
					xexec_pkg::OP_SKIP_IF_ZERO_MOVE_ACC: begin
						d.acc = operand;
						if (is_zero(operand)) begin
							d.phase = PH_DUMMY;
							d.done = 1'b0;
						end
					end
					xexec_pkg::OP_SKIP_IF_BIT_ZERO: begin
						if (!operand[q.bit_sel]) begin
							d.phase = PH_DUMMY;
							d.done = 1'b0;
						end
					end
					xexec_pkg::OP_TABLE_READ_PAGE: begin
						d.pm_addr = {q.ptr_high, q.ptr_low};
						d.pm_rd = 1'b1;
						d.phase = PH_TABLE;
						d.done = 1'b0;
					end
					xexec_pkg::OP_TABLE_READ_LAST_PAGE: begin
						d.pm_addr = {xexec_pkg::LAST_PAGE, q.ptr_low};
						d.pm_rd = 1'b1;
						d.phase = PH_TABLE;
						d.done = 1'b0;
					end
					xexec_pkg::OP_INC_TABLE_READ_PAGE: begin
						d.ptr_low = low_next;
						d.pm_addr = {q.ptr_high, low_next};
						d.pm_rd = 1'b1;
						d.phase = PH_TABLE;
						d.done = 1'b0;
					end
					xexec_pkg::OP_INC_TABLE_READ_LAST_PAGE: begin
						d.ptr_low = low_next;
						d.pm_addr = {xexec_pkg::LAST_PAGE, low_next};
						d.pm_rd = 1'b1;
						d.phase = PH_TABLE;
						d.done = 1'b0;
					end
					xexec_pkg::OP_XOR_TO_ACC: begin
						d.acc = xor_res;
						d.flags[xexec_pkg::FLAG_Z_BIT] = is_zero(xor_res);
					end
					xexec_pkg::OP_XOR_TO_MEM: begin
						d.mem[q.adr] = xor_res;
						d.flags[xexec_pkg::FLAG_Z_BIT] = is_zero(xor_res);
					end
					default: begin
						d.last_err = 1'b1;
					end
				endcase
			end
			PH_TABLE: begin
				// The program memory answers one cycle after its read strobe.
				d.cyc = q.cyc + 2'h1;
				if (!q.pm_rd) begin
					d.mem[q.adr] = pm_data_i[xexec_pkg::DATA_W-1:0];
					d.high_latch = pm_data_i[xexec_pkg::PM_DATA_W-1:xexec_pkg::DATA_W];
					d.last_cyc = xexec_pkg::CYC_TABLE;
					d.done = 1'b1;
					d.phase = PH_IDLE;
				end
			end
			PH_DUMMY: begin
				// Dummy cycles stand in for the discarded next instruction.
				d.cyc = q.cyc + 2'h1;
				if (d.cyc == xexec_pkg::CYC_SKIP) begin
					d.last_skip = 1'b1;
					d.last_cyc = xexec_pkg::CYC_SKIP;
					d.skip = 1'b1;
					d.done = 1'b1;
					d.phase = PH_IDLE;
				end
			end
			default: begin
				d.phase = PH_IDLE;
			end
		endcase

		// Busy is kept in its own flop so that the pin does not hang off a state decode.
		d.busy = (d.phase != PH_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Synchronous reset clears every field, including the data memory.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.phase <= PH_IDLE;
			q.pm_addr <= xexec_pkg::RST_PM_ADDR;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all taken straight from the state register.

	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign pm_addr_o = q.pm_addr;
	assign pm_rd_o = q.pm_rd;
	assign busy_o = q.busy;
	assign done_o = q.done;
	assign skip_o = q.skip;

endmodule
`default_nettype wire

// [testbench/pm_model.sv]
// Program memory model: synchronous address-derived words with one cycle of read latency.
`timescale 1ns/1ps
`default_nettype none
module pm_model (
	input wire logic ref_clk_i,
	input wire logic pm_rd_i,
	input wire logic [15:0] pm_addr_i,
	output logic [15:0] pm_data_o
);
	logic [15:0] word_q = 16'h0000;
	logic valid_q = 1'b0;
	// The word is a fixed mix of its address, so a wrong low byte shows in both bytes and a wrong high byte in the upper one.
	always @(posedge ref_clk_i) begin
		valid_q <= pm_rd_i;
		if (pm_rd_i) begin
			word_q <= {pm_addr_i[15:8] ^ pm_addr_i[7:0], pm_addr_i[7:0] ^ 8'h3c};
		end
	end
	// Outside the valid cycle the bus shows the inverse, so a late capture cannot pass.
	assign pm_data_o = valid_q ? word_q : ~word_q;
endmodule
`default_nettype wire

// [testbench/xexec_chk.sv]
// Timing checker for the execution unit's handshake and instruction outputs.
`timescale 1ns/1ps
`default_nettype none
module xexec_chk (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pm_rd_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic skip_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////
	// Bus answers come after one wait state and last one cycle.
	a_one_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
		else $error("bus answer not after one wait state");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	// Instruction end: single pulse, skip only with it and after three busy cycles.
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_skip_done: assert property (skip_o |-> done_o && !busy_o)
		else $error("skip without done");
	a_skip_three: assert property (skip_o |-> $past(busy_o, 1) && $past(busy_o, 2) && $past(busy_o, 3))
		else $error("taken skip not three cycles");
	a_read_latency: assert property (pm_rd_o |-> busy_o ##2 done_o)
		else $error("table read not done two cycles after fetch");
	a_busy_ends: assert property ($rose(busy_o) |-> ##[1:3] done_o)
		else $error("instruction did not end in time");
	a_short_op: assert property (done_o && !skip_o && !$past(pm_rd_o, 2) |-> !$past(busy_o, 2))
		else $error("untaken skip or xor took extra cycles");
endmodule
bind skip_table_read_xor_exec xexec_chk xexec_chk_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
	.psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pm_rd_o(pm_rd_o),
	.busy_o(busy_o), .done_o(done_o), .skip_o(skip_o));
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the skip, table-read and XOR execution unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, pm_rd, busy, done, skip;
	logic [15:0] pm_addr, pm_data;
	logic [7:0] lo, hi;
	int mismatches = 0, samples_checked = 0;
	// A 4 ns period gives the 250 MHz core clock.
	always #2 clk = ~clk;
	skip_table_read_xor_exec skip_table_read_xor_exec_inst (.ref_clk_i(clk), .resetn_i(rstn),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pm_addr_o(pm_addr),
		.pm_rd_o(pm_rd), .pm_data_i(pm_data), .busy_o(busy), .done_o(done), .skip_o(skip));
	pm_model pm_model_inst (.ref_clk_i(clk), .pm_rd_i(pm_rd), .pm_addr_i(pm_addr), .pm_data_o(pm_data));
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer held until ready; an idle edge follows so no signal is set twice at once.
	// The wait has no limit of its own; only the watchdog ends a hung handshake.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
		chk(err, 1'b0);
	endtask
	// A write whose error response is compared against the expected refusal.
	task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk(err, e);
	endtask
	function automatic logic [11:0] mem(input logic [3:0] i);
		return xexec_pkg::OFS_MEM_BASE + {6'h00, i, 2'h0};
	endfunction
	// Starts one instruction, waits for its end and compares the skip pulse.
	task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [3:0] m, input logic s);
		apb(1'b1, xexec_pkg::OFS_CMD, {20'h0_0000, m, 1'b0, b, op});
		chk(err, 1'b0);
		chk(busy, 1'b1);
		while (done !== 1'b1) begin
			@(posedge clk);
		end
		chk(skip, s);
		chk(busy, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence; flags hold software bits so any stray flag change shows.
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b1, xexec_pkg::OFS_FLAGS, 32'h0000_0005);
		apb(1'b1, mem(4'h4), 32'h0000_0010);
		run(xexec_pkg::OP_SKIP_IF_ZERO, 3'h0, 4'h3, 1'b1);
		rchk(xexec_pkg::OFS_STATUS, 32'h0000_0302);
		run(xexec_pkg::OP_SKIP_IF_ZERO, 3'h0, 4'h4, 1'b0);
		rchk(mem(4'h4), 32'h0000_0010);
		run(xexec_pkg::OP_SKIP_IF_ZERO_MOVE_ACC, 3'h0, 4'h4, 1'b0);
		rchk(xexec_pkg::OFS_ACC, 32'h0000_0010);
		run(xexec_pkg::OP_SKIP_IF_ZERO_MOVE_ACC, 3'h0, 4'h3, 1'b1);
		rchk(xexec_pkg::OFS_ACC, 32'h0000_0000);
		run(xexec_pkg::OP_SKIP_IF_BIT_ZERO, 3'h4, 4'h4, 1'b0);
		run(xexec_pkg::OP_SKIP_IF_BIT_ZERO, 3'h3, 4'h4, 1'b1);
		apb(1'b1, xexec_pkg::OFS_PTR_HIGH, 32'h0000_0012);
		apb(1'b1, xexec_pkg::OFS_PTR_LOW, 32'h0000_00fe);
		// Page, last page, then the incrementing forms; the last one wraps the low pointer.
		for (int k = 0; k < 4; k++) begin
			lo = (k < 2) ? 8'hfe : 8'hfd + k[7:0];
			hi = k[0] ? 8'hff : 8'h12;
			run(xexec_pkg::OP_TABLE_READ_PAGE + k[3:0], 3'h0, 4'h5, 1'b0);
			chk(pm_addr, {16'h0000, hi, lo});
			rchk(mem(4'h5), {24'h00_0000, lo ^ 8'h3c});
			rchk(xexec_pkg::OFS_HIGH_LATCH, {24'h00_0000, hi ^ lo});
			rchk(xexec_pkg::OFS_PTR_LOW, {24'h00_0000, lo});
			rchk(xexec_pkg::OFS_FLAGS, 32'h0000_0005);
		end
		apb(1'b1, xexec_pkg::OFS_FLAGS, 32'h0000_0001);
		apb(1'b1, xexec_pkg::OFS_ACC, 32'h0000_005a);
		apb(1'b1, mem(4'h6), 32'h0000_005a);
		run(xexec_pkg::OP_XOR_TO_ACC, 3'h0, 4'h6, 1'b0);
		rchk(xexec_pkg::OFS_ACC, 32'h0000_0000);
		rchk(xexec_pkg::OFS_FLAGS, 32'h0000_0005);
		apb(1'b1, xexec_pkg::OFS_ACC, 32'h0000_000f);
		run(xexec_pkg::OP_XOR_TO_MEM, 3'h0, 4'h6, 1'b0);
		rchk(mem(4'h6), 32'h0000_0055);
		rchk(xexec_pkg::OFS_ACC, 32'h0000_000f);
		rchk(xexec_pkg::OFS_FLAGS, 32'h0000_0001);
		// An illegal opcode ends at once with the error bit and changes nothing.
		run(4'h0, 3'h0, 4'h0, 1'b0);
		rchk(xexec_pkg::OFS_STATUS, 32'h0000_0104);
		rchk(xexec_pkg::OFS_ACC, 32'h0000_000f);
		// Refusals: read-only registers, unmapped and unaligned addresses.
		wchk(xexec_pkg::OFS_STATUS, 32'h0000_0001, 1'b1);
		wchk(xexec_pkg::OFS_HIGH_LATCH, 32'h0000_0077, 1'b1);
		rchk(xexec_pkg::OFS_HIGH_LATCH, 32'h0000_00ff);
		wchk(12'h020, 32'h0000_0001, 1'b1);
		wchk(12'h041, 32'h0000_0001, 1'b1);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		// A write that reaches its access edge while a taken skip runs is refused.
		apb(1'b1, xexec_pkg::OFS_CMD, {20'h0_0000, 4'h3, 1'b0, 3'h0, xexec_pkg::OP_SKIP_IF_ZERO});
		chk(err, 1'b0);
		wchk(xexec_pkg::OFS_ACC, 32'h0000_00aa, 1'b1);
		rchk(xexec_pkg::OFS_ACC, 32'h0000_000f);
		rchk(xexec_pkg::OFS_STATUS, 32'h0000_0302);
		finish_test;
	end
	// The sequence needs well under a thousand cycles; this cuts off a hung handshake.
	initial begin
		#20000;
		mismatches++;
		finish_test;
	end
endmodule
`default_nettype wire
